//--- common/dsswd_defs.svh
// Purpose: timing counts and codes for the dual supply supervisor
// Assumes: 200 MHz sys_clk
// Notes: times kept in their own units, cycle counts derived
`ifndef DSSWD_DEFS_SVH
`define DSSWD_DEFS_SVH
`define DSSWD_CLK_MHZ 200
`define DSSWD_HOLD0_MS 50
`define DSSWD_HOLD1_MS 200
`define DSSWD_HOLD2_MS 400
`define DSSWD_HOLD3_MS 800
`define DSSWD_WD0_MS 25
`define DSSWD_WD1_MS 200
`define DSSWD_WD2_MS 1400
`define DSSWD_MS_CYC (`DSSWD_CLK_MHZ * 1000)
`define DSSWD_BUS_MAX_KHZ 400
`define DSSWD_WD_OFF 2'h3
`define DSSWD_WD_RESET_SEL 2'h0
`define DSSWD_HOLD_RESET_SEL 2'h0
`endif

//--- common/dsswd_pkg.sv
// Purpose: shared types for the dual supply supervisor
// Assumes: nothing
// Notes: carrier struct for comparator and bus samples; bus state enum
package dsswd_pkg;
   typedef struct packed {
      logic primary_ok;
      logic second_ok;
      logic scl;
      logic sda;
   } dsswd_sense_t;
   typedef enum logic [1:0] {
      DSSWD_BUS_IDLE,
      DSSWD_BUS_STARTED
   } dsswd_bus_t;
endpackage

//--- rtl/dsswd_sync.sv
// Purpose: two-flop synchroniser for a bundle of levels
// Assumes: inputs may be asynchronous
// Notes: first stage is read only by the second
module dsswd_sync #(
   parameter int W = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // data
   input wire logic [W-1:0] d,
   input wire logic [W-1:0] rst_val,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
               meta[i] <= 1'b0;
               q[i] <= 1'b0;
            end else begin
               meta[i] <= d[i];
               q[i] <= meta[i];
            end
         end
      end
   endgenerate
endmodule

//--- rtl/dsswd_top.sv
// Purpose: supply supervisor with power-up hold-off and bus watchdog
// Assumes: comparators external, serial register protocol external
// Notes: watchdog select comes from a nonvolatile store outside this block
// Behaviour
// - open-drain reset low while supply low
// - push-pull variant drives reset high likewise
// - four hold-off delays from supply recovery
// - watchdog 25ms, 200ms, 1.4s or off
// - start then stop restarts watchdog
// - fault asserted when period elapses unserviced
// - timeout selection held across power cycles
// - fail output low while secondary low
// - fail output follows comparator, no hold-off delay
// - data receiver always watched for restart
// - bus up to 400 kHz
// - watchdog fault active-low open-drain
// - two nonvolatile bits pick watchdog period

`include "dsswd_defs.svh"

module dsswd_top
   import dsswd_pkg::*;
#(
   parameter logic ACTIVE_HIGH = 1'b0,
   parameter int MS_CYC = `DSSWD_MS_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // comparator results
   input wire logic primary_above_in,
   input wire logic second_supply_sense_in,
   // selections
   input wire logic [1:0] holdoff_sel,
   input wire logic [1:0] wd_nv_sel,
   // serial bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   // outputs
   output logic reset_out,
   output logic reset_oe,
   output logic second_supply_fail_out,
   output logic second_supply_fail_oe,
   output logic watchdog_fault_out,
   output logic watchdog_fault_oe
);
   // counter width covers the longest limit at the full clock rate
   localparam int CW = 40;
   dsswd_sense_t raw;
   dsswd_sense_t syn;
   logic [CW-1:0] hold_cnt;
   logic [CW-1:0] wd_cnt;
   logic hold_done;
   logic wd_expired;
   logic scl_d;
   logic sda_d;
   dsswd_bus_t bus_st;
   dsswd_bus_t next_bus_st;

   // limits in cycles; the products still fit 32 bits at the default rate
   function automatic logic [CW-1:0] hold_lim(input logic [1:0] s);
      case (s)
         2'h0: hold_lim = CW'(`DSSWD_HOLD0_MS * MS_CYC);
         2'h1: hold_lim = CW'(`DSSWD_HOLD1_MS * MS_CYC);
         2'h2: hold_lim = CW'(`DSSWD_HOLD2_MS * MS_CYC);
         default: hold_lim = CW'(`DSSWD_HOLD3_MS * MS_CYC);
      endcase
   endfunction

   function automatic logic [CW-1:0] wd_lim(input logic [1:0] s);
      case (s)
         2'h0: wd_lim = CW'(`DSSWD_WD0_MS * MS_CYC);
         2'h1: wd_lim = CW'(`DSSWD_WD1_MS * MS_CYC);
         default: wd_lim = CW'(`DSSWD_WD2_MS * MS_CYC);
      endcase
   endfunction

   // data edge while clock stays high; stop is the same test on inverted data
   function automatic logic sda_fall(input logic scl_now, input logic scl_was,
         input logic sda_was, input logic sda_now);
      sda_fall = scl_now && scl_was && sda_was && !sda_now;
   endfunction

   assign raw.primary_ok = primary_above_in;
   assign raw.second_ok = second_supply_sense_in;
   assign raw.scl = scl_in;
   assign raw.sda = sda_in;  // never gated

   // two flops per line; a bus edge is seen about three cycles late
   dsswd_sync #(.W(4)) u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .d(raw),
      .rst_val(4'h0),
      .q(syn)
   );

   // bus condition detect on synchronised lines; assumes scl at most 400 kHz
   wire start_seen = sda_fall(syn.scl, scl_d, sda_d, syn.sda);
   wire stop_seen = sda_fall(syn.scl, scl_d, !sda_d, !syn.sda);
   wire wd_kick = (bus_st == DSSWD_BUS_STARTED) && stop_seen;
   wire wd_off = (wd_nv_sel == `DSSWD_WD_OFF);
   wire [CW-1:0] hold_target = hold_lim(holdoff_sel);
   wire [CW-1:0] wd_target = wd_lim(wd_nv_sel);

   // counters stop at their limit, so they never wrap
   wire [CW-1:0] hold_inc = hold_cnt + CW'(1);
   wire [CW-1:0] wd_inc = wd_cnt + CW'(1);
   wire hold_hit = (hold_inc >= hold_target);
   wire wd_hit = (wd_inc >= wd_target);

   // a repeated start keeps the started state; only a later stop kicks
   always_comb begin
      next_bus_st = bus_st;
      case (bus_st)
         DSSWD_BUS_IDLE: if (start_seen) next_bus_st = DSSWD_BUS_STARTED;
         DSSWD_BUS_STARTED: if (stop_seen) next_bus_st = DSSWD_BUS_IDLE;
         default: next_bus_st = DSSWD_BUS_IDLE;
      endcase
   end

   // line history resets to the pulled-up idle level
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= syn.scl;
         sda_d <= syn.sda;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bus_st <= DSSWD_BUS_IDLE;
      end else begin
         bus_st <= next_bus_st;
      end
   end

   // hold-off counter; any dip clears it
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         hold_cnt <= '0;
         hold_done <= 1'b0;
      end else if (!syn.primary_ok) begin
         hold_cnt <= '0;
         hold_done <= 1'b0;
      end else if (!hold_done) begin
         hold_cnt <= hold_inc;
         hold_done <= hold_hit;
      end
   end

   // watchdog; count held at zero while off so no fault appears
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wd_cnt <= '0;
         wd_expired <= 1'b0;
      end else if (wd_kick || wd_off) begin
         wd_cnt <= '0;
         wd_expired <= 1'b0;
      end else if (!wd_expired) begin
         wd_cnt <= wd_inc;
         wd_expired <= wd_hit;
      end
   end

   // next pin levels; open-drain pins only ever pull low
   logic next_reset_out;
   logic next_reset_oe;
   logic next_fail_out;
   logic next_fail_oe;
   logic next_wd_out;
   logic next_wd_oe;

   assign next_reset_out = ACTIVE_HIGH ? !hold_done : 1'b0;
   assign next_reset_oe = ACTIVE_HIGH ? 1'b1 : !hold_done;
   assign next_fail_out = 1'b0;
   assign next_fail_oe = !syn.second_ok; // no hold-off on this pin
   assign next_wd_out = 1'b0;
   assign next_wd_oe = wd_expired;

   // reset is asserted during rstn as the safe state
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         reset_out <= ACTIVE_HIGH;
         reset_oe <= 1'b1;
      end else begin
         reset_out <= next_reset_out;
         reset_oe <= next_reset_oe;
      end
   end

   // fail pin pulls low while rstn holds, as the secondary is unknown
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         second_supply_fail_out <= 1'b0;
         second_supply_fail_oe <= 1'b1;
      end else begin
         second_supply_fail_out <= next_fail_out;
         second_supply_fail_oe <= next_fail_oe;
      end
   end

   // fault pin released during rstn; a fresh period starts after it
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         watchdog_fault_out <= 1'b0;
         watchdog_fault_oe <= 1'b0;
      end else begin
         watchdog_fault_out <= next_wd_out;
         watchdog_fault_oe <= next_wd_oe;
      end
   end
endmodule

//--- tb/dsswd_host.sv
// Purpose: host model that services the bus watchdog
// Assumes: lines idle high via pull-ups
// Notes: 250-cycle phases keep the bus at 400 kHz
module dsswd_host (
   // clock
   input wire logic sys_clk,
   // bus lines
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'h1;
      sda = 1'h1;
   end
   task automatic step(input logic c, input logic d);
      scl = c;
      sda = d;
      repeat (250) @(negedge sys_clk);
   endtask
   // start, one clock, stop; skip sends a stray stop
   task automatic kick(input logic skip);
      step(~skip, skip);
      step(1'h0, 1'h0);
      step(1'h1, 1'h0);
      step(1'h1, 1'h1); // stop, then bus free time before the next start
   endtask
endmodule

//--- tb/dsswd_monitor.sv
// Purpose: port checks for the supply supervisor
// Assumes: open-drain reset variant
// Notes: windows allow for the input synchronisers
module dsswd_monitor (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // inputs
   input wire logic primary_above_in,
   input wire logic second_supply_sense_in,
   input wire logic [1:0] wd_nv_sel,
   input wire logic scl_in,
   input wire logic sda_in,
   // enables
   input wire logic reset_oe,
   input wire logic second_supply_fail_oe,
   input wire logic watchdog_fault_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   sequence s_start;
      scl_in && $fell(sda_in);
   endsequence
   sequence s_stop;
      scl_in && $rose(sda_in);
   endsequence
   a_rst_on:
      assert property (!primary_above_in |-> ##[1:4] reset_oe) else $error("reset late");
   a_rst_hold:
      assert property ($rose(primary_above_in) |-> ##4 reset_oe [*8]) else $error("reset short");
   a_rst_off:
      assert property ($fell(reset_oe) |-> $past(primary_above_in, 4)) else $error("reset early");
   a_fail_on:
      assert property (!second_supply_sense_in |-> ##[1:4] second_supply_fail_oe)
         else $error("fail late");
   a_fail_off:
      assert property (second_supply_sense_in |-> ##[1:4] !second_supply_fail_oe)
         else $error("fail stuck");
   a_wd_off:
      assert property (wd_nv_sel == 2'h3 |-> ##[1:4] !watchdog_fault_oe) else $error("wd on");
   a_wd_kick:
      assert property (s_start ##[1:1000] s_stop |-> ##[1:6] !watchdog_fault_oe)
         else $error("kick lost");
   a_wd_cause:
      assert property ($rose(watchdog_fault_oe) |-> wd_nv_sel != 2'h3) else $error("wd off fired");
endmodule

//--- tb/dsswd_tb_top.sv
// Purpose: self-checking bench for the supply supervisor
// Assumes: 40 cycles stand for one ms
// Notes: checks the pin enables, which pull the lines low
`include "dsswd_defs.svh"
module dsswd_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MS = 40;
   localparam int HOLD[4] = '{`DSSWD_HOLD0_MS, `DSSWD_HOLD1_MS, `DSSWD_HOLD2_MS,
      `DSSWD_HOLD3_MS};
   logic sys_clk, rstn, pa, ss, scl, sda, roe, foe, wo, woe;
   logic ro, fo, rh, rhoe;
   logic [1:0] hsel, wsel;
   int error_cnt, checks, c;
   dsswd_top #(.MS_CYC(MS)) i_dsswd_top (
      .sys_clk, .rstn, .primary_above_in(pa), .second_supply_sense_in(ss),
      .holdoff_sel(hsel), .wd_nv_sel(wsel), .scl_in(scl), .sda_in(sda),
      .reset_out(ro), .reset_oe(roe), .second_supply_fail_out(fo),
      .second_supply_fail_oe(foe), .watchdog_fault_out(wo), .watchdog_fault_oe(woe)
   );
   // push-pull variant shares the inputs; the bench checks only its reset pin
   dsswd_top #(.ACTIVE_HIGH(1'b1), .MS_CYC(MS)) i_dsswd_top_hi (
      .sys_clk, .rstn, .primary_above_in(pa), .second_supply_sense_in(ss),
      .holdoff_sel(hsel), .wd_nv_sel(wsel), .scl_in(scl), .sda_in(sda),
      .reset_out(rh), .reset_oe(rhoe), .second_supply_fail_out(),
      .second_supply_fail_oe(), .watchdog_fault_out(), .watchdog_fault_oe()
   );
   dsswd_host i_dsswd_host (.sys_clk, .scl, .sda);
   initial begin
      sys_clk = 1'h0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic chk(input string n, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s exp %b got %b", n, e, g);
      end
   endtask
   task automatic summarize;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic t_por(input int s);
      pa = 1'h0;
      hsel = 2'(s);
      cyc(8);
      chk("reset", 1'h1, roe);
      chk("reset pin", 1'h0, ro);
      chk("reset high", 1'h1, rh);
      chk("reset drive", 1'h1, rhoe);
      pa = 1'h1;
      // a short dip halfway must restart the count
      if (s == 0) begin
         cyc(HOLD[0] * MS / 2);
         pa = 1'h0;
         cyc(2);
         pa = 1'h1;
      end
      c = 0;
      while (roe !== 1'h0 && c < HOLD[s] * MS + 20) begin
         cyc(1);
         c++;
      end
      chk("holdoff", 1'h1, c >= HOLD[s] * MS && c <= HOLD[s] * MS + 5);
      chk("reset high off", 1'h0, rh);
      $display("holdoff %0d done", s);
   endtask
   task automatic t_wd;
      i_dsswd_host.kick(1'h0);
      cyc(100);
      i_dsswd_host.kick(1'h0);
      chk("wd kept", 1'h0, woe);
      // kick returns a bus free time after its stop
      cyc(700);
      chk("wd early", 1'h0, woe);
      cyc(80);
      chk("wd late", 1'h1, woe);
      chk("wd level", 1'h0, wo);
      i_dsswd_host.kick(1'h1);
      chk("stop only", 1'h1, woe);
      i_dsswd_host.kick(1'h0);
      cyc(8);
      chk("wd clear", 1'h0, woe);
      for (int k = 1; k < 4; k++) begin
         wsel = 2'(k);
         i_dsswd_host.kick(1'h0);
         cyc(1100);
         chk("wd longer", 1'h0, woe);
      end
      $display("watchdog test done");
   endtask
   initial begin
      rstn = 1'h0;
      pa = 1'h0;
      ss = 1'h1;
      hsel = 2'h0;
      wsel = 2'h0;
      error_cnt = 0;
      checks = 0;
      cyc(8);
      rstn = 1'h1;
      ss = 1'h0;
      cyc(5);
      chk("fail low", 1'h1, foe);
      chk("fail level", 1'h0, fo);
      ss = 1'h1;
      cyc(5);
      chk("fail free", 1'h0, foe);
      $display("fail test done");
      for (int s = 3; s >= 0; s--) t_por(s);
      t_wd();
      summarize();
   end
   // about 70k cycles expected
   initial begin
      #500000;
      error_cnt++;
      summarize();
   end
endmodule
bind dsswd_top dsswd_monitor i_dsswd_monitor (
   .sys_clk, .rstn, .primary_above_in, .second_supply_sense_in, .wd_nv_sel, .scl_in,
   .sda_in, .reset_oe, .second_supply_fail_oe, .watchdog_fault_oe
);
